// [design/fault_interrupt_status.sv]
// Interrupt source, internal error and vendor fault flags with the interrupt output.
`timescale 1ns/1ps
module fault_interrupt_status
  import fault_status_pkg::*;
#(
  parameter int         ENPIN_COUNT      = 12,
  parameter logic [7:0] DEVICE_CFG_VALUE = 8'h00
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   reg_write_done,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic [7:0]                  reg_rdata,
  input  wire logic [6:0]             stored_bus_address,
  input  wire logic                   emergency_powerdown_event,
  input  wire logic                   watchdog_violation_event,
  input  wire logic [1:0]             watchdog_enable_field,
  input  wire logic                   packet_check_miscompare,
  input  wire logic                   packet_check_enable,
  input  wire logic                   alarm_event,
  input  wire logic                   alarm_wake_option,
  input  wire logic                   alarm_powerup_option,
  input  wire logic [31:0]            alarm_compare,
  input  wire logic [ENPIN_COUNT-1:0] enable_pin_short,
  input  wire logic                   oscillator_fault_in,
  input  wire logic                   crystal_enable,
  input  wire logic                   reset_out_pin_short,
  input  wire logic                   interrupt_out_pin_short,
  input  wire logic                   runtime_crc_fail,
  input  wire logic                   selftest_fail,
  input  wire logic                   regulator_fault_in,
  input  wire logic                   internal_regulator_used,
  input  wire logic                   thermal_shutdown_in,
  input  wire logic                   double_error_event,
  input  wire logic                   button_short_pulse,
  input  wire logic                   pin12_altfunc_enable,
  input  wire logic                   pin12_altfunc_select,
  input  wire logic [7:0]             vendor_fault_event,
  output logic                        interrupt_out_n
);

  // Pins and pad conditions come from outside the clock domain.
  // Only the second stage is read, because the first may still be settling.
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  wire  [3:0] pin_raw = {
    (|enable_pin_short),
    oscillator_fault_in,
    (reset_out_pin_short | interrupt_out_pin_short),
    thermal_shutdown_in
  };
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end
  // Fault conditions as seen inside the clock domain.
  wire enpin_cond  = pin_sync[3];
  wire osc_cond    = pin_sync[2] && crystal_enable;
  wire outpin_cond = pin_sync[1];
  wire tsd_cond    = pin_sync[0];

  // Write decode: one bits in a completed write request clearing.
  // A zero bit, or a one bit aimed at a flag already clear, changes nothing.
  wire       wr_primary  = reg_write_done && (reg_addr == ADDR_PRIMARY);
  wire       wr_internal = reg_write_done && (reg_addr == ADDR_INTERNAL);
  wire       wr_vendor   = reg_write_done && (reg_addr == ADDR_VENDOR);
  wire [7:0] clr_primary  = wr_primary ? reg_wdata : 8'h00;
  wire [7:0] clr_internal = wr_internal ? reg_wdata : 8'h00;
  wire [7:0] clr_vendor   = wr_vendor ? reg_wdata : 8'h00;

  // Qualified set events.
  // A disabled source cannot set its flag; only the watchdog, oscillator and regulator bits also read zero while disabled.
  wire wdt_on    = watchdog_enable_field != WDT_DISABLED;
  wire alarm_on  = alarm_wake_option || alarm_powerup_option || (alarm_compare != ALARM_NONE);
  wire set_wdt   = watchdog_violation_event && wdt_on;
  wire set_pec   = packet_check_miscompare && packet_check_enable;
  wire set_alarm = alarm_event && alarm_on;
  wire ldo_cond  = regulator_fault_in && internal_regulator_used;
  wire set_pbsp  = button_short_pulse && pin12_altfunc_enable && pin12_altfunc_select;

  logic [7:0] primary_source_reg;
  logic [7:0] internal_error_reg;
  logic [7:0] vendor_fault_flags;
  logic [7:0] primary_view;

  // Sticky primary flags.
  logic emergency_powerdown_flag;
  logic watchdog_flag;
  logic packet_flag;
  logic alarm_flag;
  logic enpin_flag;
  logic oscillator_fault;
  logic output_pin_fault;

  // Each flag is one sticky cell; a set in the same cycle as a clearing write wins.
  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_empd (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (emergency_powerdown_event),
    .condition (1'b0),
    .clear_req (clr_primary[P_EMPD]),
    .flag      (emergency_powerdown_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_wdt (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (set_wdt),
    .condition (1'b0),
    .clear_req (clr_primary[P_WDT]),
    .flag      (watchdog_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_pec (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (set_pec),
    .condition (1'b0),
    .clear_req (clr_primary[P_PEC]),
    .flag      (packet_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_rtc (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (set_alarm),
    .condition (1'b0),
    .clear_req (clr_primary[P_RTC]),
    .flag      (alarm_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b1)
  ) u_enpin (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (enpin_cond),
    .condition (enpin_cond),
    .clear_req (clr_primary[P_ENPIN]),
    .flag      (enpin_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b1)
  ) u_osc (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (osc_cond),
    .condition (osc_cond),
    .clear_req (clr_primary[P_OSC] || !crystal_enable),
    .flag      (oscillator_fault)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b1)
  ) u_outpin (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (outpin_cond),
    .condition (outpin_cond),
    .clear_req (clr_primary[P_OUTPIN]),
    .flag      (output_pin_fault)
  );

  // Sticky internal error flags.
  logic runtime_crc_fault;
  logic selftest_fault;
  logic regulator_fault;
  logic thermal_flag;
  logic double_error_flag;
  logic button_short_pulse_flag;

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_crc (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (runtime_crc_fail),
    .condition (1'b0),
    .clear_req (clr_internal[I_CRC]),
    .flag      (runtime_crc_fault)
  );

  // Only this flag is cleared; self-test result bits live elsewhere.
  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_bist (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (selftest_fail),
    .condition (1'b0),
    .clear_req (clr_internal[I_BIST]),
    .flag      (selftest_fault)
  );

  // Regulator and thermal cells refuse a clear while their condition lasts.
  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b1)
  ) u_ldo (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (ldo_cond),
    .condition (ldo_cond),
    .clear_req (clr_internal[I_LDO]),
    .flag      (regulator_fault)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b1)
  ) u_tsd (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (tsd_cond),
    .condition (tsd_cond),
    .clear_req (clr_internal[I_TSD]),
    .flag      (thermal_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_ded (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (double_error_event),
    .condition (1'b0),
    .clear_req (clr_internal[I_DED]),
    .flag      (double_error_flag)
  );

  sticky_flag #(
    .HOLD_WHILE_PRESENT (1'b0)
  ) u_pbsp (
    .clock     (clock),
    .rst_n     (rst_n),
    .set_event (set_pbsp),
    .condition (1'b0),
    .clear_req (clr_internal[I_PBSP]),
    .flag      (button_short_pulse_flag)
  );

  // Vendor fault flags are plain event flags with no condition to hold them.
  genvar g;
  generate
    for (g = 0; g < $bits(vendor_fault_flags); g++) begin : g_vendor
      sticky_flag #(
        .HOLD_WHILE_PRESENT (1'b0)
      ) u_vendor (
        .clock     (clock),
        .rst_n     (rst_n),
        .set_event (vendor_fault_event[g]),
        .condition (1'b0),
        .clear_req (clr_vendor[g]),
        .flag      (vendor_fault_flags[g])
      );
    end
  endgenerate

  // Summary bits follow their lower registers directly.
  // Bit 7 holds no storage of its own, so it drops as soon as its lower flags do.
  always_comb begin
    internal_error_reg           = RESET_FLAGS;
    internal_error_reg[I_VENDOR] = |vendor_fault_flags;
    internal_error_reg[I_CRC]    = runtime_crc_fault;
    internal_error_reg[I_BIST]   = selftest_fault;
    internal_error_reg[I_LDO]    = regulator_fault && internal_regulator_used;
    internal_error_reg[I_TSD]    = thermal_flag;
    internal_error_reg[I_DED]    = double_error_flag;
    internal_error_reg[I_PBSP]   = button_short_pulse_flag;
  end

  // The primary view masks the watchdog and oscillator bits while their functions are disabled.
  always_comb begin
    primary_source_reg             = RESET_FLAGS;
    primary_source_reg[P_INTERNAL] = |internal_error_reg;
    primary_source_reg[P_EMPD]     = emergency_powerdown_flag;
    primary_source_reg[P_WDT]      = watchdog_flag && wdt_on;
    primary_source_reg[P_PEC]      = packet_flag;
    primary_source_reg[P_RTC]      = alarm_flag;
    primary_source_reg[P_ENPIN]    = enpin_flag;
    primary_source_reg[P_OSC]      = oscillator_fault && crystal_enable;
    primary_source_reg[P_OUTPIN]   = output_pin_fault;
  end
  // The read path and the interrupt both see this one view of the primary register.
  assign primary_view = primary_source_reg;

  // Read multiplexer; unmapped offsets read zero.
  // Read data is registered, so it shows a register one cycle after its address.
  wire [7:0] next_rdata =
    (reg_addr == ADDR_PRIMARY)  ? primary_view :
    (reg_addr == ADDR_INTERNAL) ? internal_error_reg :
    (reg_addr == ADDR_VENDOR)   ? vendor_fault_flags :
    (reg_addr == ADDR_SERADDR)  ? {1'b0, stored_bus_address} :
    (reg_addr == ADDR_DEVCFG)   ? DEVICE_CFG_VALUE : READ_ZERO;

  // The interrupt is registered beside the read data, so it agrees with a read of the primary register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata       <= READ_ZERO;
      interrupt_out_n <= 1'b1;
    end else begin
      reg_rdata       <= next_rdata;
      interrupt_out_n <= ~(|primary_view);
    end
  end
endmodule

// [design/fault_status_pkg.sv]
// Register offsets, bit positions and reset values of the fault and interrupt status block.
package fault_status_pkg;
  localparam logic [7:0] ADDR_PRIMARY  = 8'h10;
  localparam logic [7:0] ADDR_INTERNAL = 8'h11;
  localparam logic [7:0] ADDR_VENDOR   = 8'h12;
  localparam logic [7:0] ADDR_SERADDR  = 8'hf9;
  localparam logic [7:0] ADDR_DEVCFG   = 8'hfa;
  localparam logic [7:0] RESET_FLAGS   = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  // Primary source bit positions.
  localparam int P_INTERNAL = 7;
  localparam int P_EMPD     = 6;
  localparam int P_WDT      = 5;
  localparam int P_PEC      = 4;
  localparam int P_RTC      = 3;
  localparam int P_ENPIN    = 2;
  localparam int P_OSC      = 1;
  localparam int P_OUTPIN   = 0;
  // Internal error bit positions.
  localparam int I_VENDOR   = 7;
  localparam int I_CRC      = 5;
  localparam int I_BIST     = 4;
  localparam int I_LDO      = 3;
  localparam int I_TSD      = 2;
  localparam int I_DED      = 1;
  localparam int I_PBSP     = 0;
  localparam logic [1:0]  WDT_DISABLED = 2'h0;
  localparam logic [31:0] ALARM_NONE   = 32'hffffffff;
endpackage

// [design/sticky_flag.sv]
// One sticky write-one-to-clear flag with optional hold-while-present behaviour.
`timescale 1ns/1ps
module sticky_flag #(
  parameter bit HOLD_WHILE_PRESENT = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic set_event,
  input  wire logic condition,
  input  wire logic clear_req,
  output logic      flag
);
  wire clear_ok = clear_req && !(HOLD_WHILE_PRESENT && condition);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (clear_ok) begin
      flag <= 1'b0;
    end
  end
endmodule

// [tb/fault_status_monitor.sv]
// Port-level checks of the fault status block.
`timescale 1ns/1ps
module fault_status_monitor (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       reg_write_done,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       emergency_powerdown_event,
  input wire logic [1:0] watchdog_enable_field,
  input wire logic       crystal_enable,
  input wire logic       runtime_crc_fail,
  input wire logic       thermal_shutdown_in,
  input wire logic [7:0] vendor_fault_event,
  input wire logic       interrupt_out_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence at_p;
    reg_addr == 8'h10;
  endsequence
  sequence at_i;
    reg_addr == 8'h11;
  endsequence
  reset_idle_a: assert property ($rose(rst_n) |-> interrupt_out_n && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  primary_irq_a: assert property ($past(reg_addr) == 8'h10 |->
    interrupt_out_n == (reg_rdata == 8'h00)) else $error("interrupt disagrees with primary");
  empd_irq_a: assert property (emergency_powerdown_event |-> ##2 !interrupt_out_n)
    else $error("no interrupt after power-down event");
  empd_read_a: assert property (emergency_powerdown_event ##1 at_p |=> reg_rdata[6])
    else $error("power-down flag not read");
  wdt_mask_a: assert property ((watchdog_enable_field == 2'h0 && reg_addr == 8'h10) [*2]
    |=> !reg_rdata[5]) else $error("watchdog flag seen while disabled");
  xtal_mask_a: assert property ((!crystal_enable && reg_addr == 8'h10) [*2]
    |=> !reg_rdata[1]) else $error("oscillator flag seen while disabled");
  crc_read_a: assert property (runtime_crc_fail ##1 at_i |=> reg_rdata[5])
    else $error("crc flag not read");
  vendor_or_a: assert property ((|vendor_fault_event) ##1 at_i |=> reg_rdata[7])
    else $error("vendor summary not set");
  thermal_hold_a: assert property (thermal_shutdown_in [*4] ##1 at_i |=> reg_rdata[2])
    else $error("thermal flag cleared while present");
  vendor_clear_a: assert property (reg_write_done && reg_addr == 8'h12 && reg_wdata == 8'hff
    && vendor_fault_event == 8'h00 ##1 reg_addr == 8'h12 |=> reg_rdata == 8'h00)
    else $error("vendor flags not cleared");
endmodule
bind fault_interrupt_status fault_status_monitor i_mon (.clock(clock), .rst_n(rst_n),
  .reg_write_done(reg_write_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .emergency_powerdown_event(emergency_powerdown_event),
  .watchdog_enable_field(watchdog_enable_field), .crystal_enable(crystal_enable),
  .runtime_crc_fail(runtime_crc_fail), .thermal_shutdown_in(thermal_shutdown_in),
  .vendor_fault_event(vendor_fault_event), .interrupt_out_n(interrupt_out_n));

// [tb/fault_status_host.sv]
// Host model: register writes, reads and interrupt servicing.
`timescale 1ns/1ps
module fault_status_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_write_done,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_write_done = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write_done = 1'b1;
    @(posedge clock);
    #1;
    reg_write_done = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask
  task automatic service(output logic [7:0] d);
    rd(8'h10, d);
  endtask
endmodule

// [tb/test_fault_interrupt_status.sv]
// Self-checking bench of the fault status block.
`timescale 1ns/1ps
module test_fault_interrupt_status;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] src = 14'h0000;
  logic [7:0]  vend = 8'h00;
  logic [1:0]  wdt_en = 2'h1;
  logic        pec_en = 1'b1;
  logic        wake = 1'b1;
  logic        xtal = 1'b1;
  logic [31:0] cmp = 32'h00000010;
  logic        af_en = 1'b1;
  logic        ldo_used = 1'b1;
  logic        alarm_pu = 1'b0;
  logic        done;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        irq_n;
  logic [7:0]  d;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [15:0] rows [14] = '{16'h1040, 16'h1020, 16'h1010, 16'h1008, 16'h1004, 16'h1002,
    16'h1001, 16'h1001, 16'h1120, 16'h1110, 16'h1108, 16'h1104, 16'h1102, 16'h1101};
  wire  [7:0]  irq8 = {7'h00, irq_n};
  always #25 clock = ~clock;
  fault_interrupt_status i_dut (.clock(clock), .rst_n(rst_n), .reg_write_done(done),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .stored_bus_address(7'h2a),
    .emergency_powerdown_event(src[0]), .watchdog_violation_event(src[1]),
    .watchdog_enable_field(wdt_en), .packet_check_miscompare(src[2]),
    .packet_check_enable(pec_en), .alarm_event(src[3]), .alarm_wake_option(wake),
    .alarm_powerup_option(alarm_pu), .alarm_compare(cmp), .enable_pin_short({src[4], 11'h000}),
    .oscillator_fault_in(src[5]), .crystal_enable(xtal), .reset_out_pin_short(src[6]),
    .interrupt_out_pin_short(src[7]), .runtime_crc_fail(src[8]), .selftest_fail(src[9]),
    .regulator_fault_in(src[10]), .internal_regulator_used(ldo_used),
    .thermal_shutdown_in(src[11]), .double_error_event(src[12]),
    .button_short_pulse(src[13]), .pin12_altfunc_enable(af_en),
    .pin12_altfunc_select(1'b1), .vendor_fault_event(vend), .interrupt_out_n(irq_n));
  fault_status_host i_host (.clock(clock), .reg_rdata(rdata), .reg_write_done(done),
    .reg_addr(addr), .reg_wdata(wdata));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(input logic [13:0] s);
    @(posedge clock);
    #1;
    src = s;
    repeat (4) @(posedge clock);
    #1;
    src = 14'h0000;
    repeat (4) @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 14; i++) begin
      pulse(14'h0001 << i);
      i_host.rd(rows[i][15:8], d);
      chk("flag", d, rows[i][7:0]);
      i_host.service(d);
      chk("primary", d, rows[i][15:8] == 8'h10 ? rows[i][7:0] : 8'h80);
      chk("irq", irq8, 8'h00);
      i_host.wr(rows[i][15:8], rows[i][7:0]);
      i_host.rd(rows[i][15:8], d);
      chk("cleared", d, 8'h00);
      i_host.rd(8'h10, d);
      chk("primary", d, 8'h00);
      chk("irq", irq8, 8'h01);
    end
    pulse(14'h0001);
    i_host.wr(8'h10, 8'hbf);
    i_host.rd(8'h10, d);
    chk("kept", d, 8'h40);
    i_host.wr(8'h10, 8'h40);
    src[11] = 1'b1;
    repeat (4) @(posedge clock);
    i_host.wr(8'h11, 8'h04);
    i_host.rd(8'h11, d);
    chk("held", d, 8'h04);
    src[11] = 1'b0;
    repeat (4) @(posedge clock);
    i_host.wr(8'h11, 8'h04);
    i_host.rd(8'h11, d);
    chk("released", d, 8'h00);
    @(posedge clock);
    #1;
    vend = 8'ha5;
    src[8] = 1'b1;
    @(posedge clock);
    #1;
    vend = 8'h00;
    src[8] = 1'b0;
    i_host.rd(8'h12, d);
    chk("vendor", d, 8'ha5);
    i_host.rd(8'h11, d);
    chk("internal", d, 8'ha0);
    i_host.wr(8'h12, 8'h05);
    i_host.rd(8'h12, d);
    chk("vendor", d, 8'ha0);
    i_host.rd(8'h10, d);
    chk("primary", d, 8'h80);
    i_host.wr(8'h12, 8'hff);
    i_host.rd(8'h12, d);
    chk("vendor", d, 8'h00);
    i_host.rd(8'h11, d);
    chk("internal", d, 8'h20);
    i_host.wr(8'h11, 8'h20);
    wdt_en = 2'h0;
    pec_en = 1'b0;
    wake = 1'b0;
    cmp = 32'hffffffff;
    xtal = 1'b0;
    af_en = 1'b0;
    ldo_used = 1'b0;
    pulse(14'h242e);
    i_host.rd(8'h10, d);
    chk("masked", d, 8'h00);
    chk("irq", irq8, 8'h01);
    i_host.rd(8'h11, d);
    chk("masked", d, 8'h00);
    i_host.rd(8'hf9, d);
    chk("address", d, 8'h2a);
    i_host.rd(8'h20, d);
    chk("unmapped", d, 8'h00);
    i_host.rd(8'hfa, d);
    chk("config", d, 8'h00);
    alarm_pu = 1'b1;
    pulse(14'h0008);
    i_host.rd(8'h10, d);
    chk("alarm", d, 8'h08);
    pulse(14'h0001);
    #1;
    rst_n = 1'b0;
    @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("irq", irq8, 8'h01);
    i_host.rd(8'h10, d);
    chk("primary", d, 8'h00);
    print_verdict();
  end
endmodule
